// [inc/blav_pkg.sv]
package blav_pkg;
    // ****************************************************
    // clock and timing
    // ****************************************************
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
    localparam int unsigned PER_UNIT_NS = 10000;
    localparam logic [10:0] PER_UNIT_CYC = 11'((PER_UNIT_NS * CLK_MHZ) / 1000);
    localparam int unsigned DEAD_STEP_NS = 40;
    localparam logic [6:0] DEAD_STEP_CYC = 7'((DEAD_STEP_NS * CLK_MHZ) / 1000);
    localparam int unsigned PWM_BASE_HZ = 25000;
    localparam int unsigned LOCK_OFF_MS = 5;
    localparam int unsigned ETR_MS = 1;
    // ****************************************************
    // thresholds and scaling
    // ****************************************************
    localparam logic [11:0] NO_MOTOR_MA = 12'h08c;
    localparam logic [19:0] SPEED_NUM = 20'hf4240;
    localparam logic [4:0] DIV_STEPS = 5'h14;
    localparam logic [15:0] AMP_MARGIN = 16'h0100;
    localparam int unsigned RM_SH = 4;
    localparam int unsigned KT_SPD_SH = 6;
    localparam int unsigned KTC_SH = 8;
    localparam int unsigned KT_WIN_SH = 8;
    localparam int unsigned AVS_SH = 4;
    // ****************************************************
    // register offsets
    // ****************************************************
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_SPD_HI = 8'h11;
    localparam logic [7:0] ADR_SPD_LO = 8'h12;
    localparam logic [7:0] ADR_PER_HI = 8'h13;
    localparam logic [7:0] ADR_PER_LO = 8'h14;
    localparam logic [7:0] ADR_KT_HI = 8'h15;
    localparam logic [7:0] ADR_KT_LO = 8'h16;
    localparam logic [7:0] ADR_FAULT = 8'h1e;
    // ****************************************************
    // fault cause bit positions and reset values
    // ****************************************************
    localparam int unsigned LK_CUR = 0;
    localparam int unsigned LK_SPD = 1;
    localparam int unsigned LK_KT = 2;
    localparam int unsigned LK_NOMTR = 3;
    localparam int unsigned LK_OL = 4;
    localparam int unsigned LK_CL = 5;
    localparam logic [5:0] FAULT_RST = 6'h00;
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [1:0] TACH_DIV_RST = 2'h0;
endpackage

// [rtl/blav_lock_fb.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - keep BEMF estimates from phase U current with resistance, and from speed with constant.
// - speed BEMF far above amplitude for estimation-error time declares abnormal-speed lock.
// - integrate BEMF over half electrical cycle as measured constant; out of window locks.
// - at open-to-closed handoff, phase U current not above 140 mA is no-motor.
// - open loop past handoff rate, no BEMF within one electrical cycle locks.
// - closed loop, present commutation period over twice previous period locks.
// - mechanical and inductive anti-surge each have their own enable.
// - mechanical anti-surge buffers command, keeps output at or above constant times speed.
// - mechanical mode 0 applies the minimum-voltage limit always.
// - mechanical mode 1 lets motor regenerate, limits only once supply reaches 24 V.
// - 4-bit dead-time field gives 16 gaps from 40 ns to 640 ns.
// - PWM rate 25 kHz with double bit 0, 50 kHz with it 1.
// - tach divider defaults 00, one pulse every electrical cycle.
// - divider also gives two per three, one per two, one per three cycles.
// - tach output held high while rotor is locked.
// - open-loop tach: follow drive, hold high, or follow drive only first start.
// - 16-bit speed equals electrical frequency times 10, from phase U zero crossings.
// - MSB read snapshots LSB into shadow; LSB read returns shadow.
// - 16-bit electrical period between phase U zero crossings, in 10 us units.
// - measured BEMF constant refreshed every electrical cycle.
// - status reports thermal, sleep or standby, overcurrent and locked flags.
// - fault cause bits set even when scheme disabled, cleared at restart.
// - enabled lock goes high impedance, sets locked flag, restarts after lock-off time.
// - six lock enable bits disable each scheme individually.
module blav_lock_fb #(
    parameter int unsigned LOCK_OFF_CYC = blav_pkg::LOCK_OFF_MS * blav_pkg::CYC_PER_MS,
    parameter int unsigned ETR_CYC = blav_pkg::ETR_MS * blav_pkg::CYC_PER_MS,
    parameter int unsigned PWM_CYC_25K = blav_pkg::CLK_HZ / blav_pkg::PWM_BASE_HZ
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic zc_u_i,
    input wire logic vcc_24v_i,
    input wire logic [11:0] i_u_ma_i,
    input wire logic [11:0] amp_i,
    input wire logic open_loop_i,
    input wire logic drive_half_i,
    input wire logic [15:0] ol_rate_i,
    input wire logic [15:0] handoff_thr_i,
    input wire logic handoff_i,
    input wire logic cur_trip_i,
    input wire logic thermal_flag_i,
    input wire logic sleep_flag_i,
    input wire logic overcurrent_flag_i,
    input wire logic [6:0] phase_resistance_setting_i,
    input wire logic [6:0] bemf_constant_setting_i,
    input wire logic [5:0] lock_scheme_enables_i,
    input wire logic mech_surge_enable_i,
    input wire logic inductive_surge_enable_i,
    input wire logic mech_surge_mode_i,
    input wire logic [3:0] dead_sel_i,
    input wire logic pwm_rate_double_i,
    input wire logic [1:0] tach_divider_sel_i,
    input wire logic [1:0] tach_open_loop_sel_i,
    input wire logic [7:0] speed_cmd_i,
    input wire logic rd_stb_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic tach_output_o,
    output logic hiz_o,
    output logic restart_o,
    output logic rotor_locked_flag_o,
    output logic [5:0] fault_cause_bits_o,
    output logic [7:0] cmd_buf_o,
    output logic [6:0] dead_cyc_o,
    output logic [12:0] pwm_period_o,
    output logic ind_surge_act_o
);
    import blav_pkg::*;

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic zc_m;
        logic zc_s;
        logic zc_d;
        logic v24_m;
        logic v24_s;
        logic [10:0] tick_cnt;
        logic [15:0] per_cnt;
        logic [15:0] period;
        logic have_per;
        logic [19:0] div_num;
        logic [16:0] div_rem;
        logic [4:0] div_cnt;
        logic [15:0] speed;
        logic [27:0] acc;
        logic [15:0] ktc;
        logic [23:0] etr_cnt;
        logic [1:0] ol_halves;
        logic [5:0] faults;
        logic locked;
        logic hiz;
        logic [23:0] off_cnt;
        logic restart;
        logic [7:0] sh_spd;
        logic [7:0] sh_per;
        logic [7:0] sh_kt;
        logic [7:0] rd_data;
        logic [2:0] half_idx;
        logic tach;
        logic first_done;
        logic [7:0] cmd_buf;
        logic [6:0] dead_cyc;
        logic [12:0] pwm_per;
        logic ind_act;
    } blav_state_t;

    blav_state_t st_ff;
    blav_state_t nxt_st;
    logic [1:0] rst_ff;
    logic rst_n;

    // ****************************************************
    // reset release
    // ****************************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];

    function automatic logic [2:0] blav_tach_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: blav_tach_len = 3'h2;
            2'h1: blav_tach_len = 3'h6;
            2'h2: blav_tach_len = 3'h4;
            2'h3: blav_tach_len = 3'h6;
        endcase
    endfunction

    function automatic logic blav_tach_lvl(input logic [1:0] sel, input logic [2:0] idx);
        unique case (sel)
            2'h0: blav_tach_lvl = (idx == 3'h0);
            2'h1: blav_tach_lvl = (idx == 3'h0) || (idx == 3'h2);
            2'h2: blav_tach_lvl = (idx < 3'h2);
            2'h3: blav_tach_lvl = (idx < 3'h3);
        endcase
    endfunction

    // ****************************************************
    // estimates and detectors
    // ****************************************************
    logic zc_rise;
    logic zc_fall;
    logic tick;
    logic [18:0] ir_drop;
    logic [15:0] bemf_cur;
    logic [22:0] spd_prod;
    logic [15:0] bemf_spd;
    logic [15:0] bemf_spd_cmd;
    logic [7:0] bemf_cmd;
    logic [15:0] kt_ref;
    logic [5:0] det;
    logic trig;
    logic avs_on;

    assign zc_rise = st_ff.zc_s && !st_ff.zc_d;
    assign zc_fall = !st_ff.zc_s && st_ff.zc_d;
    assign tick = (st_ff.tick_cnt == PER_UNIT_CYC - 11'h1);
    // current-based estimate: amplitude minus drop across winding
    assign ir_drop = (19'(i_u_ma_i) * 19'(phase_resistance_setting_i)) >> RM_SH;
    assign bemf_cur = (19'(amp_i) > ir_drop) ? 16'(19'(amp_i) - ir_drop) : 16'h0000;
    // speed-based estimate: constant times speed
    assign spd_prod = (23'(st_ff.speed) * 23'(bemf_constant_setting_i)) >> KT_SPD_SH;
    assign bemf_spd = (spd_prod[22:16] != 7'h00) ? 16'hffff : spd_prod[15:0];
    assign bemf_spd_cmd = bemf_spd >> AVS_SH;
    assign bemf_cmd = (bemf_spd_cmd[15:8] != 8'h00) ? 8'hff : bemf_spd_cmd[7:0];
    assign kt_ref = 16'(bemf_constant_setting_i) << KT_WIN_SH;

    always_comb begin
        det = 6'h00;
        if (!st_ff.hiz) begin
            det[LK_CUR] = cur_trip_i;
            det[LK_SPD] = !open_loop_i && (st_ff.etr_cnt == 24'(ETR_CYC - 1));
            // a constant outside half to twice the programmed one marks a stall
            det[LK_KT] = !open_loop_i && zc_fall && st_ff.have_per
                && ((st_ff.ktc > {kt_ref[14:0], 1'b0}) || (st_ff.ktc < {1'b0, kt_ref[15:1]}));
            det[LK_NOMTR] = handoff_i && (i_u_ma_i <= NO_MOTOR_MA);
            det[LK_OL] = open_loop_i && (ol_rate_i > handoff_thr_i) && !zc_rise
                && drive_half_i && (st_ff.ol_halves == 2'h1);
            det[LK_CL] = !open_loop_i && st_ff.have_per
                && ({1'b0, st_ff.per_cnt} > {st_ff.period, 1'b0});
        end
    end
    assign trig = |(det & lock_scheme_enables_i);
    assign avs_on = mech_surge_enable_i && (!mech_surge_mode_i || st_ff.v24_s);

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        logic [16:0] rem2;
        logic ev;
        logic [2:0] idx_n;
        rem2 = 17'h00000;
        ev = 1'b0;
        idx_n = 3'h0;
        nxt_st = st_ff;
        nxt_st.zc_m = zc_u_i;
        nxt_st.zc_s = st_ff.zc_m;
        nxt_st.zc_d = st_ff.zc_s;
        nxt_st.v24_m = vcc_24v_i;
        nxt_st.v24_s = st_ff.v24_m;
        nxt_st.restart = 1'b0;

        // period in 10 us units between rising zero crossings
        nxt_st.tick_cnt = tick ? 11'h000 : st_ff.tick_cnt + 11'h001;
        if (zc_rise) begin
            nxt_st.period = st_ff.per_cnt;
            nxt_st.per_cnt = 16'h0000;
            nxt_st.have_per = (st_ff.per_cnt != 16'h0000);
            if (st_ff.per_cnt != 16'h0000) begin
                nxt_st.div_num = SPEED_NUM;
                nxt_st.div_rem = 17'h00000;
                nxt_st.div_cnt = DIV_STEPS;
            end
        end else if (tick) begin
            if (st_ff.per_cnt == 16'hffff) begin
                // stopped motor: no crossings left to measure
                nxt_st.have_per = 1'b0;
                nxt_st.speed = 16'h0000;
            end else begin
                nxt_st.per_cnt = st_ff.per_cnt + 16'h0001;
            end
        end

        // serial divider, one quotient bit a cycle keeps the area small
        if (st_ff.div_cnt != 5'h00) begin
            rem2 = {st_ff.div_rem[15:0], st_ff.div_num[19]};
            if (rem2 >= {1'b0, st_ff.period}) begin
                nxt_st.div_rem = rem2 - {1'b0, st_ff.period};
                nxt_st.div_num = {st_ff.div_num[18:0], 1'b1};
            end else begin
                nxt_st.div_rem = rem2;
                nxt_st.div_num = {st_ff.div_num[18:0], 1'b0};
            end
            nxt_st.div_cnt = st_ff.div_cnt - 5'h01;
            if (st_ff.div_cnt == 5'h01) begin
                nxt_st.speed = (nxt_st.div_num[19:16] != 4'h0) ? 16'hffff
                    : nxt_st.div_num[15:0];
            end
        end

        // half-cycle integral of the current-based estimate
        if (st_ff.zc_s && tick) begin
            nxt_st.acc = st_ff.acc + 28'(bemf_cur);
        end
        if (zc_rise) begin
            nxt_st.acc = 28'h0000000;
        end
        if (zc_fall) begin
            nxt_st.ktc = (st_ff.acc[27:16 + KTC_SH] != '0) ? 16'hffff
                : st_ff.acc[15 + KTC_SH:KTC_SH];
        end

        // abnormal speed timer
        if (!open_loop_i && (bemf_spd > 16'(amp_i) + AMP_MARGIN) && !st_ff.hiz) begin
            if (st_ff.etr_cnt != 24'(ETR_CYC - 1)) begin
                nxt_st.etr_cnt = st_ff.etr_cnt + 24'h000001;
            end
        end else begin
            nxt_st.etr_cnt = 24'h000000;
        end

        // open-loop drive half cycles seen since the rate passed handoff
        if (!open_loop_i || zc_rise || (ol_rate_i <= handoff_thr_i)) begin
            nxt_st.ol_halves = 2'h0;
        end else if (drive_half_i && st_ff.ol_halves != 2'h2) begin
            nxt_st.ol_halves = st_ff.ol_halves + 2'h1;
        end

        // lock handling; det is gated off while hiz, so the cause bits clear to zero in the restart cycle
        if (st_ff.hiz) begin
            if (st_ff.off_cnt == 24'h000000) begin
                nxt_st.hiz = 1'b0;
                nxt_st.locked = 1'b0;
                nxt_st.restart = 1'b1;
                nxt_st.faults = det;
            end else begin
                nxt_st.off_cnt = st_ff.off_cnt - 24'h000001;
            end
        end else begin
            nxt_st.faults = st_ff.faults | det;
            if (trig) begin
                nxt_st.hiz = 1'b1;
                nxt_st.locked = 1'b1;
                nxt_st.off_cnt = 24'(LOCK_OFF_CYC - 1);
            end
        end

        // tach output
        if (handoff_i) begin
            nxt_st.first_done = 1'b1;
        end
        ev = open_loop_i ? drive_half_i : (zc_rise || zc_fall);
        if (ev) begin
            idx_n = st_ff.half_idx + 3'h1;
            if (idx_n >= blav_tach_len(tach_divider_sel_i)) begin
                idx_n = 3'h0;
            end
            nxt_st.half_idx = idx_n;
        end
        if (st_ff.locked) begin
            nxt_st.tach = 1'b1;
        end else if (open_loop_i && ((tach_open_loop_sel_i == 2'h1)
            || (tach_open_loop_sel_i == 2'h2 && st_ff.first_done))) begin
            nxt_st.tach = 1'b1;
        end else begin
            nxt_st.tach = blav_tach_lvl(tach_divider_sel_i, nxt_st.half_idx);
        end

        // anti-surge and PWM settings
        nxt_st.cmd_buf = (avs_on && speed_cmd_i < bemf_cmd) ? bemf_cmd : speed_cmd_i;
        nxt_st.ind_act = inductive_surge_enable_i && st_ff.hiz;
        nxt_st.dead_cyc = 7'(({3'h0, dead_sel_i} + 7'h01) * DEAD_STEP_CYC);
        nxt_st.pwm_per = pwm_rate_double_i ? 13'(PWM_CYC_25K / 2) : 13'(PWM_CYC_25K);

        // register reads, answered on the next edge
        if (rd_stb_i) begin
            unique case (rd_addr_i)
                ADR_STATUS: nxt_st.rd_data = {thermal_flag_i, sleep_flag_i,
                    overcurrent_flag_i, st_ff.locked, 4'h0};
                ADR_SPD_HI: begin
                    nxt_st.rd_data = st_ff.speed[15:8];
                    nxt_st.sh_spd = st_ff.speed[7:0];
                end
                ADR_SPD_LO: nxt_st.rd_data = st_ff.sh_spd;
                ADR_PER_HI: begin
                    nxt_st.rd_data = st_ff.period[15:8];
                    nxt_st.sh_per = st_ff.period[7:0];
                end
                ADR_PER_LO: nxt_st.rd_data = st_ff.sh_per;
                ADR_KT_HI: begin
                    nxt_st.rd_data = st_ff.ktc[15:8];
                    nxt_st.sh_kt = st_ff.ktc[7:0];
                end
                ADR_KT_LO: nxt_st.rd_data = st_ff.sh_kt;
                ADR_FAULT: nxt_st.rd_data = {2'h0, st_ff.faults};
                default: nxt_st.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.faults <= FAULT_RST;
            st_ff.speed <= VALUE_RST;
            st_ff.pwm_per <= 13'(PWM_CYC_25K);
            st_ff.dead_cyc <= DEAD_STEP_CYC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_o = st_ff.rd_data;
    assign tach_output_o = st_ff.tach;
    assign hiz_o = st_ff.hiz;
    assign restart_o = st_ff.restart;
    assign rotor_locked_flag_o = st_ff.locked;
    assign fault_cause_bits_o = st_ff.faults;
    assign cmd_buf_o = st_ff.cmd_buf;
    assign dead_cyc_o = st_ff.dead_cyc;
    assign pwm_period_o = st_ff.pwm_per;
    assign ind_surge_act_o = st_ff.ind_act;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    no_motor_a: assert property (handoff_i && i_u_ma_i <= NO_MOTOR_MA && !hiz_o
        |=> fault_cause_bits_o[LK_NOMTR]) else $error("no-motor cause missed");
    tach_lock_a: assert property (rotor_locked_flag_o |=> tach_output_o)
        else $error("tach low while locked");
    dead_time_a: assert property (##1 dead_cyc_o
        == 7'(({3'h0, $past(dead_sel_i)} + 7'h01) * DEAD_STEP_CYC))
        else $error("dead time mismatch");
    pwm_rate_a: assert property (pwm_rate_double_i ##1 pwm_rate_double_i
        |=> pwm_period_o == 13'(PWM_CYC_25K / 2)) else $error("pwm rate wrong");
    shadow_read_a: assert property (rd_stb_i && rd_addr_i == ADR_SPD_HI
        ##1 rd_stb_i && rd_addr_i == ADR_SPD_LO
        |=> rd_data_o == $past(st_ff.speed[7:0], 2)) else $error("shadow byte wrong");
    lock_hiz_a: assert property (trig && !hiz_o |=> hiz_o && rotor_locked_flag_o
        ##1 hiz_o [*3]) else $error("lock did not go hiz");
    fault_set_a: assert property (|det && !hiz_o
        |=> (fault_cause_bits_o & $past(det)) == $past(det))
        else $error("fault cause lost");
    avs_floor_a: assert property (mech_surge_enable_i && !mech_surge_mode_i
        |=> cmd_buf_o >= $past(bemf_cmd)) else $error("output below bemf");
    avs_regen_a: assert property (!mech_surge_enable_i || (mech_surge_mode_i && !st_ff.v24_s)
        |=> cmd_buf_o == $past(speed_cmd_i)) else $error("limit applied in regen");
    restart_a: assert property (restart_o |-> !hiz_o && $past(hiz_o))
        else $error("restart without lock-off");

    lock_cycle_c: cover property (hiz_o ##1 restart_o);
    tach_edge_c: cover property (!rotor_locked_flag_o && $rose(tach_output_o));
    pair_read_c: cover property (rd_stb_i && rd_addr_i == ADR_KT_HI
        ##1 rd_stb_i && rd_addr_i == ADR_KT_LO);
    avs_limit_c: cover property (avs_on && speed_cmd_i < bemf_cmd);
endmodule

// [dv/blav_motor_model.sv]
`timescale 1ns/1ns
// ****************************************************
// motor stand-in: phase U comparator and phase U current
// ****************************************************
module blav_motor_model #(
    // a whole turn of 20000 cycles is exactly 16 period units, so readback is exact
    parameter int unsigned HALF_CYC = 10000
) (
    input wire logic clk_sys_i,
    input wire logic spin_i,
    output logic zc_u_o,
    output logic [11:0] i_u_ma_o
);
    int unsigned cnt = 0;
    initial zc_u_o = 1'b0;
    // a stalled rotor freezes the comparator, so no zero crossing shows up
    always @(posedge clk_sys_i) begin
        if (spin_i) begin
            cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
            if (cnt == HALF_CYC - 1) begin
                zc_u_o <= ~zc_u_o;
            end
        end
    end
    // a missing or idle winding reads as zero current
    assign i_u_ma_o = spin_i ? 12'h1f4 : 12'h000;
endmodule

// [dv/bldc_lock_avs_fg_readback_bench.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module bldc_lock_avs_fg_readback_bench;
    import blav_pkg::*;
    logic clk_sys_i = 0, rstn_i = 0, spin = 0, v24 = 0, hoff = 0, stb = 0;
    logic mech_en = 0, mode = 0, dbl = 0, zc, tach, hiz, rs_p, lckd, ind;
    logic [11:0] i_u;
    logic ol = 0, dh = 0, ctrip = 0, thermal = 1, sleep = 0, ocur = 0, ind_en = 1;
    logic [15:0] orate = 16'h0000, spd;
    logic [6:0] kt = 7'h01;
    logic [1:0] tdiv = 2'h0, tol = 2'h0;
    logic [7:0] addr = 8'h00, cmd = 8'h10, rdat, hi, lo, rd_d, cbuf;
    logic [5:0] en = 6'h00, flt;
    logic [3:0] dsel = 4'h0;
    logic [6:0] dcyc;
    logic [12:0] pper;
    int err_total = 0, checked = 0;
    // ****************************************************
    // parts
    // ****************************************************
    blav_motor_model MOT (.clk_sys_i(clk_sys_i), .spin_i(spin), .zc_u_o(zc), .i_u_ma_o(i_u));
    // short lock-off and estimation times keep the run brief
    blav_lock_fb #(.LOCK_OFF_CYC(20), .ETR_CYC(10)) DUT (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .zc_u_i(zc), .vcc_24v_i(v24),
        .i_u_ma_i(i_u), .amp_i(12'h100), .open_loop_i(ol), .drive_half_i(dh),
        .ol_rate_i(orate), .handoff_thr_i(16'h0000), .handoff_i(hoff),
        .cur_trip_i(ctrip), .thermal_flag_i(thermal), .sleep_flag_i(sleep),
        .overcurrent_flag_i(ocur), .phase_resistance_setting_i(7'h01),
        .bemf_constant_setting_i(kt), .lock_scheme_enables_i(en),
        .mech_surge_enable_i(mech_en), .inductive_surge_enable_i(ind_en),
        .mech_surge_mode_i(mode), .dead_sel_i(dsel), .pwm_rate_double_i(dbl),
        .tach_divider_sel_i(tdiv), .tach_open_loop_sel_i(tol), .speed_cmd_i(cmd),
        .rd_stb_i(stb), .rd_addr_i(addr), .rd_data_o(rd_d), .tach_output_o(tach),
        .hiz_o(hiz), .restart_o(rs_p), .rotor_locked_flag_o(lckd),
        .fault_cause_bits_o(flt), .cmd_buf_o(cbuf), .dead_cyc_o(dcyc),
        .pwm_period_o(pper), .ind_surge_act_o(ind));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // ****************************************************
    // tasks
    // ****************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i) begin
            stb <= 1'b1;
            addr <= a;
        end
        @(posedge clk_sys_i) stb <= 1'b0;
        #1 d = rd_d;
    endtask
    // back-to-back pair: strobe stays up, the address steps from msb to lsb
    task automatic rd2(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_i) begin
            stb <= 1'b1;
            addr <= a;
        end
        @(posedge clk_sys_i) addr <= a + 8'h01;
        #1 d[15:8] = rd_d;
        @(posedge clk_sys_i) stb <= 1'b0;
        #1 d[7:0] = rd_d;
    endtask
    task automatic pulse_handoff();
        @(posedge clk_sys_i) hoff <= 1'b1;
        @(posedge clk_sys_i) hoff <= 1'b0;
        cyc(1);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************************************************
    // watchdog: the tests need about 72000 cycles
    // ****************************************************
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        err_total++;
        give_verdict();
    end
    // ****************************************************
    // tests
    // ****************************************************
    initial begin
        cyc(4);
        @(posedge clk_sys_i) rstn_i <= 1'b1;
        cyc(4);
        `CHK(pper, 13'h1388)
        rd(8'h1f, rdat);
        `CHK(rdat, 8'h00)
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_sys_i) dsel <= 4'(k);
            cyc(3);
            `CHK(dcyc, 7'((k + 1) * 5))
        end
        @(posedge clk_sys_i) dbl <= 1'b1;
        cyc(3);
        `CHK(pper, 13'h09c4)
        done("pwm");
        pulse_handoff();
        `CHK(flt, 6'h08)
        `CHK(hiz, 1'b0)
        @(posedge clk_sys_i) en <= 6'h08;
        pulse_handoff();
        `CHK(hiz, 1'b1)
        `CHK(lckd, 1'b1)
        `CHK(ind, 1'b1)
        `CHK(tach, 1'b1)
        rd(ADR_STATUS, rdat);
        `CHK(rdat, 8'h90)
        for (int k = 0; k < 40 && rs_p !== 1'b1; k++) cyc(1);
        `CHK(rs_p, 1'b1)
        cyc(2);
        `CHK(hiz, 1'b0)
        `CHK(flt, 6'h00)
        @(posedge clk_sys_i) begin
            thermal <= 1'b0;
            sleep <= 1'b1;
            ocur <= 1'b1;
        end
        rd(ADR_STATUS, rdat);
        `CHK(rdat, 8'h60)
        done("lock");
        @(posedge clk_sys_i) spin <= 1'b1;
        // two rising crossings give one whole measured period
        cyc(31000);
        pulse_handoff();
        `CHK(flt[3], 1'b0)
        rd(ADR_KT_LO, rdat);
        `CHK(rdat, 8'h00)
        rd(ADR_PER_HI, hi);
        rd(ADR_PER_LO, lo);
        `CHK({hi, lo}, 16'h0010)
        rd2(ADR_SPD_HI, spd);
        `CHK(spd, 16'hf424)
        done("readback");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_i) begin
                mech_en <= (k > 0);
                mode <= (k > 1);
                v24 <= (k == 3);
            end
            cyc(6);
            `CHK(cbuf, (k == 1 || k == 3) ? 8'h3d : 8'h10)
        end
        done("surge");
        @(posedge clk_sys_i) begin
            ol <= 1'b1;
            tol <= 2'h1;
        end
        cyc(2);
        `CHK(tach, 1'b1)
        @(posedge clk_sys_i) ol <= 1'b0;
        @(posedge clk_sys_i) begin
            en <= 6'h20;
            spin <= 1'b0;
        end
        for (int k = 0; k < 50000 && hiz !== 1'b1; k++) cyc(1);
        `CHK(flt[5], 1'b1)
        `CHK(hiz, 1'b1)
        done("stall");
        give_verdict();
    end
endmodule
